// [dv/testbench.sv]
// Self-checking bench of the winder input block.
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst = 1, run_cmd = 0, run, stall = 0, t3 = 0, t4 = 0, e;
  logic psel = 0, pen = 0, pwr = 0, prdy, perr, ten, den, sen;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, r, x = 32'h0000_34e2;
  logic [11:0] a1 = 0, a2 = 0;
  logic [15:0] fq = 0, tq = 0, tqr, spd, thk, st_tq;
  logic [15:0] thv [4];
  logic [1:0] slot;
  int n_fail = 0, n_checks = 0, cyc = 0, i;
  wic_line_model i_line (.clk_i(clk), .run_cmd_i(run_cmd), .run_o(run));
  wic_top i_dut (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .RUN_I(run), .STALL_I(stall),
    .THK3_I(t3), .THK4_I(t4), .AIN1_I(a1), .AIN2_I(a2), .FREQ_HZ_I(fq), .TENSION_TORQUE_I(tq),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .TORQUE_REF_O(tqr), .TORQUE_EN_O(ten), .DRIVE_EN_O(den),
    .SPEED_REF_O(spd), .SPEED_REF_EN_O(sen), .THK_SLOT_O(slot), .THICKNESS_O(thk));
  initial forever #4 clk = ~clk;
  // A hang ends the run as a failure.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Percent in hundredths, clamped outside the two points.
  function automatic logic [31:0] pct(input int v, lo, hi);
    if (v <= lo) return 0;
    if (v >= hi) return 10000;
    return (v - lo) * 10000 / (hi - lo);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x_e);
    n_checks++;
    if (g !== x_e)
    begin
      $display("wrong value at %0t got %h exp %h", $time, g, x_e);
      n_fail++;
    end
  endtask
  // One APB transfer; request held until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd; e = perr;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task automatic set(input int c, input logic [15:0] v);
    case (c)
      0: a1 <= v[11:0];
      1: a2 <= v[11:0];
      default: fq <= v;
    endcase
  endtask
  // Two-point calibration of one channel: 0 first analog, 1 second, 2 frequency.
  task automatic cal(input int c, input logic [15:0] lo, input logic [15:0] hi);
    set(c, lo);
    apb(1, 8'(4 + 4 * c), 32'h0000_0001);
    apb(0, 8'h30, 0); chk(r[4 + 2 * c +: 2], 1);
    apb(0, 8'h34, 0); chk(r, lo);
    apb(1, 8'h10, 0);
    apb(0, 8'h30, 0); chk(r[4 + 2 * c +: 2], 2);
    set(c, hi);
    apb(1, 8'h10, 0);
    apb(0, 8'h30, 0); chk(r[4 + 2 * c +: 2], 0);
    chk(r[10 + c], lo > hi);
  endtask
  task automatic settle(input int v, input logic [7:0] a, input logic [31:0] x_e);
    repeat (v) @(posedge clk);
    apb(0, a, 0);
    chk(r, x_e);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    st_tq = rnd();
    apb(1, 8'h14, st_tq);
    for (i = 0; i < 4; i++)
    begin
      thv[i] = rnd();
      apb(1, 8'(8'h20 + 4 * i), thv[i]);
    end
    for (i = 0; i < 16; i++)
    begin
      tq <= rnd();
      {run_cmd, stall, t3, t4} <= i[3:0];
      repeat (12) @(posedge clk);
      chk(den, run_cmd);
      chk(ten, run_cmd | stall);
      chk(tqr, run_cmd ? tq : (stall ? st_tq : 16'h0000));
      chk(thk, thv[{t3, t4}]);
      chk(slot, {t3, t4});
    end
    $display("run stall thickness test done");
    for (i = 1; i <= 12; i++)
    begin
      apb(1, 8'h00, i);
      settle(4, 8'h00, i);
      chk(sen, !(i inside {5, 6, 7, 11, 12}));
    end
    apb(1, 8'h00, 13);
    settle(1, 8'h00, 12);
    apb(0, 8'h50, 0); chk(e, 1);
    $display("configuration test done");
    apb(1, 8'h00, 1);
    cal(1, 100, 2100);
    i = 100 + rnd() % 2000;
    a2 <= i[11:0];
    settle(40, 8'h3C, pct(i, 100, 2100));
    a2 <= 50;
    settle(40, 8'h3C, 0);
    apb(1, 8'h18, 100);
    apb(1, 8'h1C, 300);
    cal(0, 1000, 3000);
    cal(0, 3000, 1000);
    a1 <= 2000;
    settle(40, 8'h40, 5000);
    settle(1, 8'h44, 200);
    cal(2, 100, 1100);
    i = 100 + rnd() % 1000;
    fq <= i[15:0];
    settle(40, 8'h38, pct(i, 100, 1100));
    chk(spd, pct(i, 100, 1100));
    fq <= 2000;
    settle(40, 8'h38, 10000);
    apb(1, 8'h00, 2);
    a2 <= 1100;
    settle(40, 8'h38, 5000);
    settle(1, 8'h3C, 0);
    $display("calibration test done");
    end_sim();
  end
endmodule

// [dv/wic_line_model.sv]
// Model of the line drive run contact facing the winder input block.
`timescale 1ns/1ns
module wic_line_model #(
  parameter int RAMP = 4
)
(
  input wire logic clk_i,
  input wire logic run_cmd_i,
  output logic run_o
);
  int ramp_q;
  // The contact stays closed while the line ramps down, so the block sees run end late.
  always_ff @(posedge clk_i)
  begin
    if (run_cmd_i)
      ramp_q <= RAMP;
    else if (ramp_q > 0)
      ramp_q <= ramp_q - 1;
  end
  assign run_o = run_cmd_i || (ramp_q > 0);
endmodule

// [dv/wic_top_props.sv]
// Port checker of the winder input block.
`timescale 1ns/1ns
module wic_props (
  input wire logic CLOCK_I, RST_I, CE_I, RUN_I, STALL_I, THK3_I, THK4_I,
  input wire logic [15:0] TENSION_TORQUE_I,
  input wire logic PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O, PSLVERR_O, TORQUE_EN_O, DRIVE_EN_O, SPEED_REF_EN_O,
  input wire logic [15:0] TORQUE_REF_O, SPEED_REF_O,
  input wire logic [1:0] THK_SLOT_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I || !CE_I);
  // Contact inputs pass two sync stages and an output stage.
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_answer; !PREADY_O ##1 PREADY_O; endsequence
  property p_wait; s_setup ##1 (PSEL_I && PENABLE_I) |-> s_answer; endproperty
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  property p_err; PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I; endproperty
  property p_wdat; PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0000_0000; endproperty
  property p_drv_on; RUN_I [*4] |=> DRIVE_EN_O; endproperty
  property p_drv_off; !RUN_I [*4] |=> !DRIVE_EN_O; endproperty
  property p_off; (!RUN_I && !STALL_I) [*4] |=> !TORQUE_EN_O && TORQUE_REF_O == 16'h0000; endproperty
  property p_run;
    (RUN_I && $stable(TENSION_TORQUE_I)) [*4] |=> TORQUE_EN_O && TORQUE_REF_O == $past(TENSION_TORQUE_I);
  endproperty
  property p_stall; (STALL_I && !RUN_I) [*4] |=> TORQUE_EN_O; endproperty
  property p_slot; $stable({THK3_I, THK4_I}) [*4] |=> THK_SLOT_O == {$past(THK3_I), $past(THK4_I)}; endproperty
  property p_spd; SPEED_REF_O <= 16'h2710 && (SPEED_REF_EN_O || SPEED_REF_O == 16'h0000); endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error outside a completing access");
  a_wdat: assert property (p_wdat) else $error("read data not zero on write");
  a_drv_on: assert property (p_drv_on) else $error("drive enable missing");
  a_drv_off: assert property (p_drv_off) else $error("drive enable stuck");
  a_off: assert property (p_off) else $error("torque while idle");
  a_run: assert property (p_run) else $error("running torque wrong");
  a_stall: assert property (p_stall) else $error("stall torque not enabled");
  a_slot: assert property (p_slot) else $error("thickness slot wrong");
  a_spd: assert property (p_spd) else $error("speed reference out of range");
endmodule
bind wic_top wic_props i_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .RUN_I(RUN_I),
  .STALL_I(STALL_I), .THK3_I(THK3_I), .THK4_I(THK4_I), .TENSION_TORQUE_I(TENSION_TORQUE_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TORQUE_EN_O(TORQUE_EN_O), .DRIVE_EN_O(DRIVE_EN_O),
  .SPEED_REF_EN_O(SPEED_REF_EN_O), .TORQUE_REF_O(TORQUE_REF_O), .SPEED_REF_O(SPEED_REF_O),
  .THK_SLOT_O(THK_SLOT_O));

// [rtl/wic_cal_ch.sv]
// Two-point calibration sequencer and percent scaler for one input.
`timescale 1ns/1ns
`include "wic_map.svh"
module wic_cal_ch
  import wic_pkg::*;
#(
  parameter int IN_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  wic_cal_if.ch cal
);

  // The scaler arithmetic is sized for the shared value width.
  if (IN_W > `WIC_VAL_W || IN_W < 2)
  begin : g_chk
    $error("wic_cal_ch: IN_W out of range");
  end

  localparam int REM_W = `WIC_VAL_W + 14;

  wic_phase_t phase_q; // Sequencer phase.
  logic [`WIC_VAL_W-1:0] lo_q; // Committed low point.
  logic [`WIC_VAL_W-1:0] hi_q; // Committed high point.
  logic [`WIC_VAL_W-1:0] lo_tmp_q; // Low point awaiting the high one.
  logic err_q; // Error of the last sequence.
  logic [`WIC_PCT_W-1:0] pct_q; // Scaled output.
  logic busy_q; // Divider running.
  logic [3:0] cnt_q; // Quotient bit being resolved.
  logic [REM_W-1:0] rem_q; // Remainder of the division.
  logic [`WIC_VAL_W-1:0] den_q; // Span hi minus lo.
  logic [`WIC_PCT_W-1:0] quo_q; // Quotient built so far.

  // ------------------------------------------------------------------
  // Combinational terms
  // ------------------------------------------------------------------
  wire logic below = cal.raw <= lo_q; // see RL20
  wire logic above = cal.raw >= hi_q; // see RL20
  wire logic [`WIC_VAL_W-1:0] diff = cal.raw - lo_q;
  wire logic [REM_W-1:0] num = REM_W'(diff) * REM_W'(`WIC_PCT_FULL);
  wire logic [REM_W-1:0] trial = REM_W'(den_q) << cnt_q;
  wire logic fits = trial <= rem_q;
  wire logic [`WIC_PCT_W-1:0] bit_v = `WIC_PCT_W'(1) << cnt_q;
  wire logic bad_pair = lo_tmp_q > cal.raw;

  assign cal.phase = phase_q;
  assign cal.err = err_q;
  assign cal.pct = pct_q;

  // ------------------------------------------------------------------
  // Calibration sequencer
  // ------------------------------------------------------------------
  // A failed pair leaves lo_q and hi_q untouched, so scaling keeps working.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= WIC_PH_IDLE;
      lo_q <= `WIC_CAL_LO_RST;
      hi_q <= `WIC_CAL_HI_RST;
      lo_tmp_q <= `WIC_CAL_LO_RST;
      err_q <= 1'b0;
    end
    else if (ce_i)
    begin
      case (phase_q)
        WIC_PH_LOW:
        begin
          if (cal.enter)
          begin
            lo_tmp_q <= cal.raw; // see RL9
            phase_q <= WIC_PH_HIGH; // see RL9
          end
        end
        WIC_PH_HIGH:
        begin
          if (cal.enter)
          begin
            phase_q <= WIC_PH_IDLE;
            if (bad_pair)
            begin
              err_q <= 1'b1; // see RL10
            end
            else
            begin
              lo_q <= lo_tmp_q; // see RL9
              hi_q <= cal.raw;
            end
          end
        end
        default:
        begin
          phase_q <= WIC_PH_IDLE;
        end
      endcase
      // A new trigger restarts from the low phase in any state.
      if (cal.trig)
      begin
        phase_q <= WIC_PH_LOW; // see RL8
        err_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Scaler: one quotient bit per cycle, restarts on the live value
  // ------------------------------------------------------------------
  // A sequential divider costs 15 cycles of latency but no wide array.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pct_q <= '0;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      rem_q <= '0;
      den_q <= '0;
      quo_q <= '0;
    end
    else if (ce_i)
    begin
      if (!busy_q)
      begin
        if (below)
        begin
          pct_q <= '0; // see RL20
        end
        else if (above)
        begin
          pct_q <= `WIC_PCT_FULL; // see RL20
        end
        else
        begin
          busy_q <= 1'b1; // see RL12
          cnt_q <= 4'hD;
          rem_q <= num;
          den_q <= hi_q - lo_q;
          quo_q <= '0;
        end
      end
      else
      begin
        if (fits)
        begin
          rem_q <= rem_q - trial;
        end
        if (cnt_q == 4'h0)
        begin
          busy_q <= 1'b0;
          pct_q <= fits ? (quo_q | bit_v) : quo_q;
        end
        else
        begin
          quo_q <= fits ? (quo_q | bit_v) : quo_q;
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end

endmodule

// [rtl/wic_top.sv]
// Run, stall, thickness and calibration logic of the winder input block.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "wic_map.svh"
module wic_top
  import wic_pkg::*;
#(
  parameter int AIN_W = 12,
  parameter int FREQ_W = 16
)
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic RUN_I,
  input wire logic STALL_I,
  input wire logic THK3_I,
  input wire logic THK4_I,
  input wire logic [AIN_W-1:0] AIN1_I,
  input wire logic [AIN_W-1:0] AIN2_I,
  input wire logic [FREQ_W-1:0] FREQ_HZ_I,
  input wire logic [15:0] TENSION_TORQUE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [15:0] TORQUE_REF_O,
  output logic TORQUE_EN_O,
  output logic DRIVE_EN_O,
  output logic [15:0] SPEED_REF_O,
  output logic SPEED_REF_EN_O,
  output logic [1:0] THK_SLOT_O,
  output logic [15:0] THICKNESS_O
);

  // Inputs wider than the channel value cannot be scaled.
  if (AIN_W > `WIC_VAL_W || FREQ_W > `WIC_VAL_W || AIN_W < 2 || FREQ_W < 2)
  begin : g_chk
    $error("wic_top: input width out of range");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] pin_s1_q; // First stage, read only by the second.
  logic [3:0] pin_s2_q; // Second stage, safe to use.
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else if (CE_I)
    begin
      pin_s1_q <= {THK4_I, THK3_I, STALL_I, RUN_I};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire logic run = pin_s2_q[0];
  wire logic stall = pin_s2_q[1];
  // Input three is the high select bit, input four the low one.
  wire logic [1:0] slot = {pin_s2_q[2], pin_s2_q[3]}; // see RL5

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  logic [3:0] cfg_q; // Loaded configuration number.
  logic [15:0] stall_tq_q; // Fixed stall torque level.
  logic [15:0] core_dia_q; // Core diameter, user units.
  logic [15:0] max_dia_q; // Maximum diameter, user units.
  logic [15:0] thk_q [4]; // Thickness slots 0 to 3.
  logic [2:0] trig_q; // Calibration start pulses.
  logic enter_q; // Enter press pulse.

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  // The slave inserts one wait state so that read data come from a flop.
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  wire logic acc = PSEL_I && PENABLE_I;
  wire logic done = acc && pready_q;
  wire logic wr = done && PWRITE_I;
  wire logic [3:0] wcfg = PWDATA_I[3:0];
  wire logic cfg_ok = PWDATA_I[31:4] == 28'h000_0000 && wcfg != 4'h0 && wcfg <= `WIC_CFG_MAX; // see RL18
  wire logic hit_cfg = PADDR_I == `WIC_OFS_CONFIG;
  wire logic hit_c1 = PADDR_I == `WIC_OFS_AIN1_CAL;
  wire logic hit_c2 = PADDR_I == `WIC_OFS_AIN2_CAL;
  wire logic hit_cf = PADDR_I == `WIC_OFS_FREQ_CAL;
  wire logic hit_ent = PADDR_I == `WIC_OFS_ENTER;
  wire logic hit_stq = PADDR_I == `WIC_OFS_STALL_TQ;
  wire logic hit_core = PADDR_I == `WIC_OFS_CORE_DIA;
  wire logic hit_max = PADDR_I == `WIC_OFS_MAX_DIA;
  wire logic hit_thk = PADDR_I[7:4] == `WIC_OFS_THK0 >> 4 && PADDR_I[1:0] == 2'b00;
  wire logic [1:0] thk_idx = PADDR_I[3:2];
  wire logic start = PWDATA_I == `WIC_CAL_START; // see RL8

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  wic_cal_if ain1_if ();
  wic_cal_if ain2_if ();
  wic_cal_if freq_if ();
  assign ain1_if.raw = `WIC_VAL_W'(AIN1_I);
  assign ain2_if.raw = `WIC_VAL_W'(AIN2_I);
  // The frequency front end already delivers hertz, shown live in both phases.
  assign freq_if.raw = `WIC_VAL_W'(FREQ_HZ_I); // see RL11
  assign ain1_if.trig = trig_q[0];
  assign ain2_if.trig = trig_q[1];
  assign freq_if.trig = trig_q[2];

  // Enter goes to one sequence only, analog 1 first, then analog 2, then frequency.
  wire logic cal1 = ain1_if.phase != WIC_PH_IDLE;
  wire logic cal2 = ain2_if.phase != WIC_PH_IDLE;
  wire logic calf = freq_if.phase != WIC_PH_IDLE;
  assign ain1_if.enter = enter_q && cal1; // see RL9
  assign ain2_if.enter = enter_q && !cal1 && cal2;
  assign freq_if.enter = enter_q && !cal1 && !cal2 && calf;

  wic_cal_ch #(.IN_W(AIN_W)) u_ain1 (.clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I), .cal(ain1_if));
  wic_cal_ch #(.IN_W(AIN_W)) u_ain2 (.clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I), .cal(ain2_if));
  wic_cal_ch #(.IN_W(FREQ_W)) u_freq (.clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I), .cal(freq_if));

  // ------------------------------------------------------------------
  // Configuration roles
  // ------------------------------------------------------------------
  wic_src_t line_src; // Line speed source.
  wic_src_t tens_src; // Tension setpoint source.
  wic_src_t dia_src; // External diameter source.
  logic no_speed_ref; // Line and roll speed diameter setups.
  always_comb
  begin
    line_src = WIC_SRC_AIN1;
    tens_src = WIC_SRC_AIN2;
    dia_src = WIC_SRC_NONE;
    no_speed_ref = 1'b0;
    case (cfg_q)
      4'h1:
      begin
        line_src = WIC_SRC_FREQ; // see RL16
        dia_src = WIC_SRC_AIN1; // see RL7
      end
      4'h2:
      begin
        line_src = WIC_SRC_AIN2; // see RL17
        tens_src = WIC_SRC_NONE;
        dia_src = WIC_SRC_AIN1;
      end
      4'h4, 4'hA:
      begin
        line_src = WIC_SRC_FREQ;
      end
      4'h8:
      begin
        line_src = WIC_SRC_FREQ;
        dia_src = WIC_SRC_AIN1;
      end
      4'h5, 4'h6, 4'h7, 4'hB, 4'hC:
      begin
        no_speed_ref = 1'b1; // see RL6
      end
      default:
      begin
        line_src = WIC_SRC_AIN1;
      end
    endcase
  end

  // Picks one channel's percent by source code.
  function automatic logic [`WIC_PCT_W-1:0] pick(input wic_src_t s, input logic [`WIC_PCT_W-1:0] a1,
                                                   input logic [`WIC_PCT_W-1:0] a2,
                                                   input logic [`WIC_PCT_W-1:0] f);
    case (s)
      WIC_SRC_AIN1: pick = a1;
      WIC_SRC_AIN2: pick = a2;
      WIC_SRC_FREQ: pick = f;
      default: pick = '0;
    endcase
  endfunction

  wire logic [`WIC_PCT_W-1:0] line_pct = pick(line_src, ain1_if.pct, ain2_if.pct, freq_if.pct); // see RL15
  wire logic [`WIC_PCT_W-1:0] tens_pct = pick(tens_src, ain1_if.pct, ain2_if.pct, freq_if.pct); // see RL12
  wire logic [`WIC_PCT_W-1:0] dia_pct = pick(dia_src, ain1_if.pct, ain2_if.pct, freq_if.pct); // see RL13

  // Diameter in user units; a maximum below the core gives the core value.
  wire logic [15:0] span = max_dia_q > core_dia_q ? max_dia_q - core_dia_q : 16'h0000;
  wire logic [29:0] prod = 30'(span) * 30'(dia_pct);
  wire logic [29:0] quot = prod / 30'(`WIC_PCT_FULL);
  wire logic [15:0] dia_user = core_dia_q + quot[15:0]; // see RL14

  // Live value shown while any sequence runs.
  wire logic [15:0] live = cal1 ? ain1_if.raw : cal2 ? ain2_if.raw : freq_if.raw; // see RL8

  wire logic [31:0] status = {12'h000, cfg_q, 3'h0, freq_if.err, ain2_if.err, ain1_if.err,
                              freq_if.phase, ain2_if.phase, ain1_if.phase, slot, stall, run};

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  logic [31:0] rdata;
  logic rhit;
  always_comb
  begin
    rhit = 1'b1;
    rdata = 32'h0000_0000;
    if (hit_cfg)
      rdata = {28'h000_0000, cfg_q};
    else if (hit_c1 || hit_c2 || hit_cf || hit_ent)
      rdata = 32'h0000_0000;
    else if (hit_stq)
      rdata = {16'h0000, stall_tq_q};
    else if (hit_core)
      rdata = {16'h0000, core_dia_q};
    else if (hit_max)
      rdata = {16'h0000, max_dia_q};
    else if (hit_thk)
      rdata = {16'h0000, thk_q[thk_idx]};
    else if (PADDR_I == `WIC_OFS_STATUS)
      rdata = status;
    else if (PADDR_I == `WIC_OFS_CAL_LIVE)
      rdata = {16'h0000, live};
    else if (PADDR_I == `WIC_OFS_LINE_PCT)
      rdata = {18'h0_0000, line_pct};
    else if (PADDR_I == `WIC_OFS_TENS_PCT)
      rdata = {18'h0_0000, tens_pct};
    else if (PADDR_I == `WIC_OFS_DIA_RATIO)
      rdata = {18'h0_0000, dia_pct};
    else if (PADDR_I == `WIC_OFS_DIA_USER)
      rdata = {16'h0000, dia_user};
    else
      rhit = 1'b0;
  end

  // ------------------------------------------------------------------
  // APB handshake
  // ------------------------------------------------------------------
  // Data and error are loaded on the first access cycle and shown on the second.
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (CE_I)
    begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !rhit;
      prdata_q <= (acc && !pready_q && !PWRITE_I) ? rdata : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  // Invalid configuration numbers are ignored so the roles never go undefined.
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      cfg_q <= `WIC_CFG_RST;
      stall_tq_q <= 16'h0000;
      core_dia_q <= 16'h0000;
      max_dia_q <= 16'h0000;
      thk_q <= '{default: 16'h0000};
      trig_q <= 3'b000;
      enter_q <= 1'b0;
    end
    else if (CE_I)
    begin
      trig_q <= {wr && hit_cf && start, wr && hit_c2 && start, wr && hit_c1 && start}; // see RL8
      enter_q <= wr && hit_ent;
      if (wr && hit_cfg && cfg_ok)
        cfg_q <= wcfg; // see RL7
      if (wr && hit_stq)
        stall_tq_q <= PWDATA_I[15:0];
      if (wr && hit_core)
        core_dia_q <= PWDATA_I[15:0];
      if (wr && hit_max)
        max_dia_q <= PWDATA_I[15:0];
      if (wr && hit_thk)
        thk_q[thk_idx] <= PWDATA_I[15:0];
    end
  end

  // ------------------------------------------------------------------
  // Drive outputs
  // ------------------------------------------------------------------
  // Run is assumed held through the ramp down, so no hold timer is kept here.
  logic [15:0] tq_q;
  logic tq_en_q;
  logic drv_en_q;
  logic [15:0] spd_q;
  logic spd_en_q;
  logic [1:0] slot_q;
  logic [15:0] thk_out_q;
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      tq_q <= 16'h0000;
      tq_en_q <= 1'b0;
      drv_en_q <= 1'b0;
      spd_q <= 16'h0000;
      spd_en_q <= 1'b0;
      slot_q <= 2'b00;
      thk_out_q <= 16'h0000;
    end
    else if (CE_I)
    begin
      drv_en_q <= run; // see RL19
      if (run)
      begin
        tq_q <= TENSION_TORQUE_I; // see RL1 see RL4 see RL2
        tq_en_q <= 1'b1;
      end
      else if (stall)
      begin
        tq_q <= stall_tq_q; // see RL3
        tq_en_q <= 1'b1;
      end
      else
      begin
        tq_q <= 16'h0000; // see RL1
        tq_en_q <= 1'b0;
      end
      spd_en_q <= !no_speed_ref; // see RL6
      spd_q <= no_speed_ref ? 16'h0000 : {2'b00, line_pct};
      slot_q <= slot; // see RL5
      thk_out_q <= thk_q[slot];
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign TORQUE_REF_O = tq_q;
  assign TORQUE_EN_O = tq_en_q;
  assign DRIVE_EN_O = drv_en_q;
  assign SPEED_REF_O = spd_q;
  assign SPEED_REF_EN_O = spd_en_q;
  assign THK_SLOT_O = slot_q;
  assign THICKNESS_O = thk_out_q;

endmodule

// [shared/wic_cal_if.sv]
// Link between the top module and one calibration and scaling channel.
`timescale 1ns/1ns
`include "wic_map.svh"
interface wic_cal_if;
  import wic_pkg::*;
  logic [`WIC_VAL_W-1:0] raw; // Live input value.
  logic trig; // One-cycle calibration start.
  logic enter; // One-cycle Enter press.
  wic_phase_t phase; // Current calibration phase.
  logic err; // Last calibration failed.
  logic [`WIC_PCT_W-1:0] pct; // Scaled value, hundredths of percent.
  modport ctl (output raw, trig, enter, input phase, err, pct);
  modport ch (input raw, trig, enter, output phase, err, pct);
endinterface

// [shared/wic_map.svh]
// Register offsets, field positions, reset values and constants of the winder input block.
//
// Function
// RL1: Torque output only while run or stall is active.
// RL2: Line drive holds run closed while running.
// RL3: Stall input sends fixed programmed torque level.
// RL4: Run overrides stall when both are active.
// RL5: Inputs three and four select thickness slot.
// RL6: Speed reference except line/roll speed configurations.
// RL7: Writing configuration number loads input roles.
// RL8: Trigger write starts low phase, live value.
// RL9: Enter captures low, then high point.
// RL10: Low above high flags error, keeps scaling.
// RL11: Frequency calibration shows live hertz value.
// RL12: Tension setpoint scales zero to hundred percent.
// RL13: External diameter ratio scales core to full.
// RL14: Diameter in user units from ratio.
// RL15: Line speed scales stopped to maximum speed.
// RL16: Config one: frequency speed, analog two tension.
// RL17: Config two: analog speeds, analog diameter.
// RL18: Twelve configurations, one to twelve valid.
// RL19: Drive enable output follows the run input.
// RL20: Scaled percent clamped between zero and hundred.
`ifndef WIC_MAP_SVH
`define WIC_MAP_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define WIC_OFS_CONFIG 8'h00
`define WIC_OFS_AIN1_CAL 8'h04
`define WIC_OFS_AIN2_CAL 8'h08
`define WIC_OFS_FREQ_CAL 8'h0C
`define WIC_OFS_ENTER 8'h10
`define WIC_OFS_STALL_TQ 8'h14
`define WIC_OFS_CORE_DIA 8'h18
`define WIC_OFS_MAX_DIA 8'h1C
`define WIC_OFS_THK0 8'h20
`define WIC_OFS_STATUS 8'h30
`define WIC_OFS_CAL_LIVE 8'h34
`define WIC_OFS_LINE_PCT 8'h38
`define WIC_OFS_TENS_PCT 8'h3C
`define WIC_OFS_DIA_RATIO 8'h40
`define WIC_OFS_DIA_USER 8'h44

// ------------------------------------------------------------------
// Field positions of the status word
// ------------------------------------------------------------------
`define WIC_ST_RUN 0
`define WIC_ST_STALL 1
`define WIC_ST_SLOT 2
`define WIC_ST_PH1 4
`define WIC_ST_PH2 6
`define WIC_ST_PHF 8
`define WIC_ST_ERR 10
`define WIC_ST_CFG 16

// ------------------------------------------------------------------
// Widths, reset values and scaling constants
// ------------------------------------------------------------------
`define WIC_VAL_W 16
`define WIC_PCT_W 14
`define WIC_PCT_FULL 14'h2710
`define WIC_CAL_LO_RST 16'h0000
`define WIC_CAL_HI_RST 16'hFFFF
`define WIC_CFG_RST 4'h1
`define WIC_CFG_MAX 4'hC
`define WIC_CAL_START 32'h0000_0001

`endif

// [shared/wic_pkg.sv]
// Types shared by the winder input block modules.
package wic_pkg;

  // Calibration sequencer phase.
  typedef enum logic [1:0] {
    WIC_PH_IDLE = 2'b00,
    WIC_PH_LOW = 2'b01,
    WIC_PH_HIGH = 2'b10
  } wic_phase_t;

  // Source of a conditioned signal.
  typedef enum logic [1:0] {
    WIC_SRC_NONE = 2'b00,
    WIC_SRC_AIN1 = 2'b01,
    WIC_SRC_AIN2 = 2'b10,
    WIC_SRC_FREQ = 2'b11
  } wic_src_t;

endpackage
